//--- core/pnp_config_register_bank.v
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "pnp_regs_defs.vh"
module pnp_config_register_bank
(
   input  wire        pclk,                  // 40 MHz clock
   input  wire        presetn,               // async reset, low
   input  wire        psel,                  // apb select
   input  wire        penable,               // apb access phase
   input  wire        pwrite,                // apb direction
   input  wire [11:0] paddr,                 // byte address, index*4
   input  wire [31:0] pwdata,                // write data
   output reg  [31:0] prdata,                // read data
   output reg         pready,                // transfer done
   output reg         pslverr,               // unmapped index or misaligned address
   input  wire        key_seen,              // key detector pulse
   input  wire [7:0]  key_id,                // id of key seen
   input  wire        eeprom_valid,          // EEPROM contents good
   input  wire        res_valid,             // loader byte offered
   input  wire [7:0]  res_data,              // loader byte
   output reg         res_ready,             // holder free
   input  wire        load_strobe,           // EEPROM image load
   input  wire [3:0]  load_io_base,          // image io base
   input  wire [3:0]  load_irq_sel,          // image irq select
   input  wire        load_irq_type,         // image irq type
   input  wire [2:0]  load_dma_sel,          // image dma select
   input  wire [7:0]  load_vendor,           // image vendor byte
   input  wire        dev_irq,               // core interrupt request
   input  wire        dev_dma_req,           // core dma request
   output reg  [7:0]  read_port_address,     // read data port address
   output reg  [7:0]  isolation_value,       // isolation register
   output reg         device_reset,          // reset logical devices
   output reg  [1:0]  config_state,          // configuration state
   output reg         active,                // device activated
   output reg  [1:0]  range_check_enable,    // range check command
   output reg  [3:0]  io_base_match,         // io base decode
   output reg  [3:0]  rom_base_match,        // rom base decode
   output reg         rom_wide_access,       // 16-bit rom cycles
   output reg  [3:0]  rom_size,              // rom size
   output reg  [4:0]  shared_mem_base,       // shared memory base
   output reg         shared_mem_wide_access,// 16-bit shared memory
   output reg  [3:0]  shared_mem_size,       // shared memory size
   output reg         irq_level_mode,        // 1 level, 0 edge
   output reg  [7:0]  vendor_options,        // vendor option byte
   output reg         irq_out,               // routed interrupt
   output reg         irq_oe,                // interrupt pin driven
   output reg  [3:0]  irq_route,             // selected irq
   output reg         dma_out,               // routed dma request
   output reg         dma_oe,                // dma pin driven
   output reg  [2:0]  dma_route              // selected channel
);
   reg  [7:0] card_select_number;
   reg  [7:0] logical_device_index;
   reg  [3:0] irq_sel;
   reg  [2:0] dma_sel;
   reg  [7:0] next_rdata;
   reg        next_err;
   wire [7:0] idx    = paddr[9:2];
   wire [7:0] wb     = pwdata[7:0];
   wire       access = psel && penable && pready;
   wire       wr     = access && pwrite && (paddr[1:0] == 2'b00);
   // a misaligned read must not consume a resource byte
   wire       rd     = access && !pwrite && (paddr[1:0] == 2'b00);
   wire       legacy = vendor_options[`BIT_LEGACY];
   wire       holder_full;
   wire [7:0] holder_data;
   wire       holder_ready;
   wire       do_wait_key = wr && idx == `IDX_CONFIG_CTRL
                            && wb[`BIT_WAIT_KEY];
   // a standard key is honoured only outside legacy mode and with a
   // good image; the vendor key always gets through
   wire       key_ok = key_seen && config_state == `ST_WAIT_KEY
                       && ((key_id == `KEY_STANDARD && !legacy
                            && eeprom_valid)                 // [RQ14] [RQ15]
                           || key_id == `KEY_VENDOR);       // [RQ16] [RQ17]
   wire       take = rd && idx == `IDX_RES_BYTE && holder_full;

   res_byte_holder #(.WIDTH(8)) u_holder
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .flush    (do_wait_key),
      .in_valid (res_valid),
      .in_data  (res_data),
      .in_ready (holder_ready),
      .take     (take),                                     // [RQ8]
      .full     (holder_full),
      .data     (holder_data)
   );

   // read mux; fixed bits are constants here and never stored, save vendor bit 7, a stored zero
   always @*
   begin
      next_rdata = 8'h00;
      next_err   = 1'b0;
      case (idx)
         `IDX_ISOLATION   : next_rdata = isolation_value;          // [RQ3]
         `IDX_RES_BYTE    : next_rdata = holder_data;              // [RQ8]
         `IDX_RES_STATUS  : next_rdata = {7'h00, holder_full};     // [RQ9]
         `IDX_CSN         : next_rdata = card_select_number;       // [RQ10]
         `IDX_LDEV        : next_rdata = logical_device_index;     // [RQ1]
         `IDX_ACTIVATE    : next_rdata = {7'h00, active};          // [RQ11]
         `IDX_RANGE_CHECK : next_rdata = {6'h00, range_check_enable};
         `IDX_IO_BASE_HI  : next_rdata = `FIX_IO_BASE_HI
                                        | {7'h00, io_base_match[3]}; // [RQ23]
         `IDX_IO_BASE_LO  : next_rdata = {io_base_match[2:0], 5'h00};
         `IDX_IRQ_SEL     : next_rdata = {4'h0, irq_sel};
         `IDX_IRQ_TYPE    : next_rdata = {6'h00, ~irq_level_mode,
                                          irq_level_mode};         // [RQ21]
         `IDX_DMA_SEL     : next_rdata = {5'h00, dma_sel};
         `IDX_ROM_BASE_HI : next_rdata = `FIX_ROM_BASE_HI
                                        | {7'h00, rom_base_match[3]};
         `IDX_ROM_BASE_LO : next_rdata = {rom_base_match[2:0], 5'h00};
         `IDX_ROM_WIDTH   : next_rdata = {6'h00, rom_wide_access, 1'b0};
         `IDX_ROM_SIZE_HI : next_rdata = `FIX_ROM_SIZE_HI
                                        | {7'h00, rom_size[3]};    // [RQ13]
         `IDX_ROM_SIZE_LO : next_rdata = {rom_size[2:0], 5'h00};
         `IDX_SM_BASE_HI  : next_rdata = `FIX_SM_BASE_HI
                                        | {6'h00, shared_mem_base[4:3]};
         `IDX_SM_BASE_LO  : next_rdata = {shared_mem_base[2:0], 5'h00};
         `IDX_SM_WIDTH    : next_rdata = {6'h00, shared_mem_wide_access,
                                          1'b0};
         `IDX_SM_SIZE_HI  : next_rdata = `FIX_SM_SIZE_HI
                                        | {7'h00, shared_mem_size[3]};
         `IDX_SM_SIZE_LO  : next_rdata = {shared_mem_size[2:0], 5'h00};
         `IDX_VENDOR      : next_rdata = vendor_options;
         `IDX_KEY_STATUS  : next_rdata = {6'h00, config_state};
         // write-only control ports read as zero
         `IDX_READ_PORT, `IDX_CONFIG_CTRL, `IDX_WAKE : next_rdata = 8'h00;
         default          : next_err = 1'b1;
      endcase
   end

   // apb slave: no wait state, every access completes in two edges
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            prdata  <= pwrite ? 32'h0000_0000 : {24'h000000, next_rdata};
            pslverr <= next_err || (paddr[1:0] != 2'b00);
         end
      end
   end

   // configuration state and control registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         config_state         <= `ST_WAIT_KEY;
         card_select_number   <= 8'h00;
         logical_device_index <= 8'h00;
         read_port_address    <= 8'h00;
         isolation_value      <= 8'h00;
         device_reset         <= 1'b0;
         active               <= 1'b0;
         range_check_enable   <= 2'b00;
         io_base_match        <= 4'h0;
         irq_sel              <= `RST_IRQ_SEL;
         irq_level_mode       <= 1'b0;
         dma_sel              <= `RST_DMA_SEL;
         rom_base_match       <= 4'h0;
         rom_wide_access      <= 1'b0;
         rom_size             <= 4'h0;
         shared_mem_base      <= 5'h00;
         shared_mem_wide_access <= 1'b0;
         shared_mem_size      <= 4'h0;
         vendor_options       <= 8'h00;
      end
      else
      begin
         device_reset <= 1'b0;
         if (key_ok)
            config_state <= `ST_SLEEP;
         if (load_strobe)
         begin
            io_base_match  <= load_io_base;
            irq_sel        <= load_irq_sel;
            irq_level_mode <= load_irq_type;
            dma_sel        <= load_dma_sel;
            // bit 7 of the vendor byte is a fixed zero
            vendor_options <= {1'b0, load_vendor[6:0]}; // [RQ19]
         end
         if (wr)
         begin
            case (idx)
               `IDX_READ_PORT   : read_port_address <= wb;  // [RQ2]
               `IDX_ISOLATION   :
               begin
                  isolation_value <= wb;                    // [RQ3]
                  if (config_state == `ST_SLEEP)
                     config_state <= `ST_ISOLATE;
               end
               `IDX_CONFIG_CTRL :
               begin
                  if (wb[`BIT_CLEAR_CSN])
                     card_select_number <= 8'h00;           // [RQ4]
                  if (wb[`BIT_WAIT_KEY])
                     config_state <= `ST_WAIT_KEY;          // [RQ5]
                  if (wb[`BIT_RESET_ALL])
                  begin
                     device_reset <= 1'b1;                  // [RQ6]
                     active       <= 1'b0;
                  end
               end
               `IDX_WAKE        :
                  if (config_state != `ST_WAIT_KEY)
                     config_state <= (wb == card_select_number)
                                     ? `ST_CONFIG : `ST_SLEEP; // [RQ7]
               `IDX_CSN         : card_select_number <= wb; // [RQ10]
               `IDX_LDEV        : logical_device_index <= wb; // [RQ1]
               `IDX_ACTIVATE    : active <= wb[0];          // [RQ11]
               `IDX_RANGE_CHECK : range_check_enable <= wb[1:0]; // [RQ12]
               `IDX_IO_BASE_HI  : io_base_match[3] <= wb[0]; // [RQ13]
               `IDX_IO_BASE_LO  : io_base_match[2:0] <= wb[7:5];
               `IDX_IRQ_SEL     : irq_sel <= wb[3:0];
               `IDX_IRQ_TYPE    : irq_level_mode <= wb[0];  // [RQ20]
               `IDX_DMA_SEL     : dma_sel <= wb[2:0];
               `IDX_ROM_BASE_HI : rom_base_match[3] <= wb[0]; // [RQ23]
               `IDX_ROM_BASE_LO : rom_base_match[2:0] <= wb[7:5];
               `IDX_ROM_WIDTH   : rom_wide_access <= wb[1];
               `IDX_ROM_SIZE_HI : rom_size[3] <= wb[0];
               `IDX_ROM_SIZE_LO : rom_size[2:0] <= wb[7:5];
               `IDX_SM_BASE_HI  : shared_mem_base[4:3] <= wb[1:0];
               `IDX_SM_BASE_LO  : shared_mem_base[2:0] <= wb[7:5];
               `IDX_SM_WIDTH    : shared_mem_wide_access <= wb[1];
               `IDX_SM_SIZE_HI  : shared_mem_size[3] <= wb[0];
               `IDX_SM_SIZE_LO  : shared_mem_size[2:0] <= wb[7:5];
               `IDX_VENDOR      : vendor_options <= {1'b0, wb[6:0]}; // [RQ18]
               default          : ;
            endcase
         end
      end
   end

   // pins stay undriven until activation, so the host can reroute first
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_out   <= 1'b0;
         irq_oe    <= 1'b0;
         irq_route <= `RST_IRQ_SEL;
         dma_out   <= 1'b0;
         dma_oe    <= 1'b0;
         dma_route <= `RST_DMA_SEL;
         res_ready <= 1'b0;
      end
      else
      begin
         irq_oe    <= active;                               // [RQ22]
         irq_out   <= active && dev_irq;
         irq_route <= irq_sel;
         dma_oe    <= active;                               // [RQ22]
         dma_out   <= active && dev_dma_req;
         dma_route <= dma_sel;
         res_ready <= holder_ready && !(res_valid && holder_ready);
      end
   end
endmodule // pnp_config_register_bank

//--- core/pnp_regs_defs.vh
// Behaviour
// RQ1 - control registers 0x00-0x07, activation, range check
// RQ2 - index 0x00 holds read port address
// RQ3 - index 0x01 serves serial isolation
// RQ4 - bit2 of 0x02 clears select number
// RQ5 - bit1 of 0x02 returns to key wait
// RQ6 - bit0 of 0x02 resets all logical devices
// RQ7 - write 0x03 wakes only on number match
// RQ8 - read 0x04 gives next resource byte
// RQ9 - bit0 of 0x05 reports resource byte ready
// RQ10 - index 0x06 holds card select number
// RQ11 - bit0 of 0x30 activates device
// RQ12 - bits 1:0 of 0x31 enable range check
// RQ13 - resource registers with fixed constant bits
// RQ14 - by default always answers configuration software; code ignores standard key 6A while eeprom_valid is low
// RQ15 - legacy mode ignores standard key 6A
// RQ16 - legacy mode only vendor key reconfigures
// RQ17 - vendor key 6B recognised without EEPROM
// RQ18 - host sets legacy via bit6 of 0xF0
// RQ19 - legacy preferably set from EEPROM vendor byte
// RQ20 - interrupt type bit one means level
// RQ21 - interrupt polarity reads complement of type
// RQ22 - no irq or dma drive until activated
// RQ23 - fixed bits ignore writes, read constant
`ifndef PNP_REGS_DEFS_VH
`define PNP_REGS_DEFS_VH
`define IDX_READ_PORT     8'h00
`define IDX_ISOLATION     8'h01
`define IDX_CONFIG_CTRL   8'h02
`define IDX_WAKE          8'h03
`define IDX_RES_BYTE      8'h04
`define IDX_RES_STATUS    8'h05
`define IDX_CSN           8'h06
`define IDX_LDEV          8'h07
`define IDX_ACTIVATE      8'h30
`define IDX_RANGE_CHECK   8'h31
`define IDX_ROM_BASE_HI   8'h40
`define IDX_ROM_BASE_LO   8'h41
`define IDX_ROM_WIDTH     8'h42
`define IDX_ROM_SIZE_HI   8'h43
`define IDX_ROM_SIZE_LO   8'h44
`define IDX_SM_BASE_HI    8'h48
`define IDX_SM_BASE_LO    8'h49
`define IDX_SM_WIDTH      8'h4A
`define IDX_SM_SIZE_HI    8'h4B
`define IDX_SM_SIZE_LO    8'h4C
`define IDX_IO_BASE_HI    8'h60
`define IDX_IO_BASE_LO    8'h61
`define IDX_IRQ_SEL       8'h70
`define IDX_IRQ_TYPE      8'h71
`define IDX_DMA_SEL       8'h74
`define IDX_VENDOR        8'hF0
`define IDX_KEY_STATUS    8'hF8
`define BIT_CLEAR_CSN     2
`define BIT_WAIT_KEY      1
`define BIT_RESET_ALL     0
`define BIT_LEGACY        6
`define FIX_IO_BASE_HI    8'h02
`define FIX_ROM_BASE_HI   8'h0C
`define FIX_ROM_SIZE_HI   8'hFE
`define FIX_SM_BASE_HI    8'h0C
`define FIX_SM_SIZE_HI    8'hFE
`define RST_IRQ_SEL       4'h3
`define RST_DMA_SEL       3'h3
`define KEY_STANDARD      8'h6A
`define KEY_VENDOR        8'h6B
`define ST_WAIT_KEY       2'h0
`define ST_SLEEP          2'h1
`define ST_ISOLATE        2'h2
`define ST_CONFIG         2'h3
`endif

//--- core/res_byte_holder.v
`timescale 1ns/1ps
// one-byte holding stage between the EEPROM loader and the host reader
module res_byte_holder
#(
   parameter WIDTH = 8
)
(
   input  wire             pclk,      // clock
   input  wire             presetn,   // async reset, low
   input  wire             flush,     // drop held byte
   input  wire             in_valid,  // loader offers a byte
   input  wire [WIDTH-1:0] in_data,   // loader byte
   output wire             in_ready,  // holder can take a byte
   input  wire             take,      // host consumed the byte
   output reg              full,      // byte held
   output reg  [WIDTH-1:0] data       // held byte
);
   assign in_ready = ~full;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         full <= 1'b0;
         data <= {WIDTH{1'b0}};
      end
      else if (flush)
         full <= 1'b0;
      else if (in_valid && !full)
      begin
         full <= 1'b1;
         data <= in_data;
      end
      else if (take)
         full <= 1'b0;
   end
endmodule // res_byte_holder

//--- tb/pnp_bank_checker_sva.sv
`timescale 1ns/1ps
module pnp_bank_checker
(
   input wire logic        pclk,           // clock
   input wire logic        presetn,        // reset, low
   input wire logic        psel,           // select
   input wire logic        penable,        // access phase
   input wire logic        pwrite,         // direction
   input wire logic [11:0] paddr,          // address
   input wire logic [31:0] pwdata,         // write data
   input wire logic        pready,         // done
   input wire logic        pslverr,        // error
   input wire logic        key_seen,       // key pulse
   input wire logic [7:0]  key_id,         // key id
   input wire logic        device_reset,   // device reset
   input wire logic [1:0]  config_state,   // state
   input wire logic        active,         // activated
   input wire logic [7:0]  vendor_options, // vendor byte
   input wire logic        irq_oe,         // irq driven
   input wire logic        dma_oe          // dma driven
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wr(logic [7:0] idx);
      psel && penable && pready && pwrite && !pslverr
         && paddr == {2'h0, idx, 2'h0};
   endsequence
   property p_ready_after_setup;
      s_setup |=> pready ##1 !pready;
   endproperty
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   property p_active_write;
      s_wr(8'h30) |=> active == $past(pwdata[0]);
   endproperty
   property p_wait_key;
      s_wr(8'h02) ##0 pwdata[1] |=> config_state == 2'h0;
   endproperty
   property p_reset_all;
      s_wr(8'h02) ##0 pwdata[0] |=> device_reset;
   endproperty
   property p_irq_gate;
      irq_oe |-> $past(active);
   endproperty
   property p_dma_gate;
      dma_oe |-> $past(active);
   endproperty
   property p_legacy_key;
      key_seen && key_id == 8'h6A && vendor_options[6]
         && config_state == 2'h0 |=> config_state == 2'h0;
   endproperty
   property p_vendor_key;
      key_seen && key_id == 8'h6B && config_state == 2'h0
         |=> config_state == 2'h1;
   endproperty
   property p_vendor_fixed;
      vendor_options[7] == 1'b0;
   endproperty
   a_vendor_fixed: assert property (p_vendor_fixed)
      else $error("vendor fixed bit set");
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("ready not one cycle after setup");
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("error without ready");
   a_active_write: assert property (p_active_write)
      else $error("activation not written");
   a_wait_key: assert property (p_wait_key)
      else $error("no return to key wait");
   a_reset_all: assert property (p_reset_all)
      else $error("no device reset");
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq driven while inactive");
   a_dma_gate: assert property (p_dma_gate)
      else $error("dma driven while inactive");
   a_legacy_key: assert property (p_legacy_key)
      else $error("standard key taken in legacy mode");
   a_vendor_key: assert property (p_vendor_key)
      else $error("vendor key ignored");
endmodule // pnp_bank_checker
bind pnp_config_register_bank pnp_bank_checker i_pnp_bank_checker
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .key_seen(key_seen), .key_id(key_id),
   .device_reset(device_reset), .config_state(config_state),
   .active(active), .vendor_options(vendor_options),
   .irq_oe(irq_oe), .dma_oe(dma_oe)
);

//--- tb/res_loader_model.sv
`timescale 1ns/1ps
module res_loader_model
(
   input  wire       pclk,      // clock
   input  wire       presetn,   // async reset, low
   input  wire       offer,     // present next byte
   input  wire       done,      // host saw it, withdraw
   output reg        res_valid, // byte offered
   output reg  [7:0] res_data   // offered byte
);
   reg [7:0] next_byte;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         res_valid <= 1'b0;
         res_data  <= 8'hA5;
         next_byte <= 8'h3C;
      end
      else if (done)
      begin
         // released data must not look like the last byte
         res_valid <= 1'b0;
         res_data  <= ~res_data;
      end
      else if (offer)
      begin
         res_valid <= 1'b1;
         res_data  <= next_byte;
         next_byte <= next_byte + 8'h47;
      end
endmodule // res_loader_model

//--- tb/test_pnp_config_register_bank.sv
`timescale 1ns/1ps
`include "pnp_regs_defs.vh"
module test_pnp_config_register_bank;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0;
   reg key_seen = 0, eeprom_valid = 1, offer = 0, done = 0, ls = 0;
   reg [7:0] key_id = 0, l_vend = 0;
   reg [3:0] l_io = 0, l_irq = 0;
   reg [2:0] l_dma = 0;
   reg l_type = 0, dev_irq = 1, dev_dma = 1;
   wire [31:0] prdata;
   wire pready, pslverr, res_valid, active, irq_oe, dma_oe, lvl;
   wire res_rdy, irq_out, dma_out;
   wire [7:0] res_data, rpa;
   wire [3:0] irq_route;
   wire [2:0] dma_route;
   integer fails = 0, checks = 0, i, n;
   reg [31:0] rdata;
   reg rerr;
   localparam [143:0] IDX = {8'h60, 8'h61, 8'h40, 8'h41, 8'h42, 8'h43,
      8'h44, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h70, 8'h71, 8'h74,
      8'hF0, 8'h31, 8'h06};
   localparam [143:0] RST = {8'h02, 8'h00, 8'h0C, 8'h00, 8'h00, 8'hFE,
      8'h00, 8'h0C, 8'h00, 8'h00, 8'hFE, 8'h00, 8'h03, 8'h02, 8'h03,
      8'h00, 8'h00, 8'h00};
   localparam [143:0] ONE = {8'h03, 8'hE0, 8'h0D, 8'hE0, 8'h02, 8'hFF,
      8'hE0, 8'h0F, 8'hE0, 8'h02, 8'hFF, 8'hE0, 8'h0F, 8'h01, 8'h07,
      8'h7F, 8'h03, 8'hFF};
   pnp_config_register_bank i_pnp_config_register_bank
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .key_seen(key_seen),
      .key_id(key_id), .eeprom_valid(eeprom_valid),
      .res_valid(res_valid), .res_data(res_data), .res_ready(res_rdy),
      .load_strobe(ls), .load_io_base(l_io), .load_irq_sel(l_irq),
      .load_irq_type(l_type), .load_dma_sel(l_dma),
      .load_vendor(l_vend), .dev_irq(dev_irq), .dev_dma_req(dev_dma),
      .read_port_address(rpa), .isolation_value(), .device_reset(),
      .config_state(), .active(active), .range_check_enable(),
      .io_base_match(), .rom_base_match(), .rom_wide_access(),
      .rom_size(), .shared_mem_base(), .shared_mem_wide_access(),
      .shared_mem_size(), .irq_level_mode(lvl), .vendor_options(),
      .irq_out(irq_out), .irq_oe(irq_oe), .irq_route(irq_route),
      .dma_out(dma_out),
      .dma_oe(dma_oe), .dma_route(dma_route)
   );
   res_loader_model i_res_loader_model
   (
      .pclk(pclk), .presetn(presetn), .offer(offer), .done(done),
      .res_valid(res_valid), .res_data(res_data)
   );
   initial
   begin
      forever #12.5 pclk = ~pclk;
   end
   task check(input [31:0] seen, input [31:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task stop_test;
   begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // the request stands until pready is sampled high
   task apb(input w, input [7:0] idx, input [31:0] d);
      integer t;
   begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      t = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 20)
      begin
         t = t + 1;
         @(posedge pclk);
      end
      if (t == 20)
      begin
         fails = fails + 1;
         stop_test;
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   end
   endtask
   task rd(input [7:0] idx, input [31:0] exp);
   begin
      apb(0, idx, 0);
      check(rdata, exp);
   end
   endtask
   task pulse_key(input [7:0] k);
   begin
      @(posedge pclk);
      key_seen <= 1;
      key_id <= k;
      @(posedge pclk);
      key_seen <= 0;
      repeat (2) @(posedge pclk);
   end
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      check(irq_oe, 0);
      for (i = 17; i >= 0; i = i - 1)
      begin
         rd(IDX[i*8 +: 8], RST[i*8 +: 8]);
         apb(1, IDX[i*8 +: 8], 32'hFFFFFFFF);
         rd(IDX[i*8 +: 8], ONE[i*8 +: 8]);
      end
      apb(0, 8'h08, 0);
      check(rerr, 1);
      $display("register map test done");
      apb(1, `IDX_READ_PORT, 32'h9B);
      // the write lands at the access edge; look once it has settled
      @(negedge pclk);
      check(rpa, 8'h9B);
      apb(1, `IDX_VENDOR, 32'h40);
      pulse_key(`KEY_STANDARD);
      rd(`IDX_KEY_STATUS, 0);
      eeprom_valid <= 0;
      pulse_key(`KEY_VENDOR);
      rd(`IDX_KEY_STATUS, 1);
      apb(1, `IDX_CSN, 5);
      apb(1, `IDX_WAKE, 5);
      rd(`IDX_KEY_STATUS, 3);
      apb(1, `IDX_WAKE, 4);
      rd(`IDX_KEY_STATUS, 1);
      rd(`IDX_CSN, 5);
      apb(1, `IDX_CONFIG_CTRL, 4);
      rd(`IDX_CSN, 0);
      apb(1, `IDX_ISOLATION, 8'h11);
      rd(`IDX_KEY_STATUS, 2);
      apb(1, `IDX_CONFIG_CTRL, 2);
      rd(`IDX_KEY_STATUS, 0);
      apb(1, `IDX_VENDOR, 0);
      pulse_key(`KEY_STANDARD);
      rd(`IDX_KEY_STATUS, 0);
      eeprom_valid <= 1;
      pulse_key(`KEY_STANDARD);
      rd(`IDX_KEY_STATUS, 1);
      $display("key and wake test done");
      check({irq_out, dma_out, irq_oe, dma_oe}, 0);
      apb(1, `IDX_ACTIVATE, 1);
      repeat (2) @(posedge pclk);
      check({irq_oe, dma_oe, irq_out, dma_out}, 4'hF);
      check({irq_route, dma_route, lvl}, 8'hFF);
      apb(1, `IDX_CONFIG_CTRL, 1);
      repeat (3) @(posedge pclk);
      check({irq_oe, dma_oe, active, irq_out, dma_out}, 0);
      rd(`IDX_ACTIVATE, 0);
      $display("activation test done");
      for (i = 0; i < 2; i = i + 1)
      begin
         @(posedge pclk);
         offer <= 1;
         @(posedge pclk);
         offer <= 0;
         rdata = 0;
         for (n = 0; n < 10 && rdata[0] !== 1'b1; n = n + 1)
            apb(0, `IDX_RES_STATUS, 0);
         check(rdata, 1);
         check(res_rdy, 0);
         @(posedge pclk);
         done <= 1;
         @(posedge pclk);
         done <= 0;
         rd(`IDX_RES_BYTE, 8'h3C + i * 8'h47);
         rd(`IDX_RES_STATUS, 0);
         check(res_rdy, 1);
      end
      $display("resource byte test done");
      @(posedge pclk);
      {l_io, l_irq, l_type, l_dma, l_vend} <= {4'h5, 4'h5, 1'b0, 3'h5,
         8'h20};
      ls <= 1;
      @(posedge pclk);
      ls <= 0;
      rd(`IDX_IO_BASE_LO, 8'hA0);
      rd(`IDX_IRQ_TYPE, 8'h02);
      rd(`IDX_DMA_SEL, 8'h05);
      rd(`IDX_VENDOR, 8'h20);
      $display("image load test done");
      stop_test;
   end
endmodule // test_pnp_config_register_bank
